// file: logic/csm_pkg.sv
// Shared types and constants for the communication security mode control
package csm_pkg;
   localparam int NUM_KEYSETS = 4;
   localparam int NUM_ZONES   = 16;
   localparam int ZONE_W      = 4;
   localparam int KEY_W       = 2;
   localparam int WORD_W      = 64;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_AUTH   = 2'b01,
      MODE_ENC    = 2'b10
   } comm_mode_t;

   typedef enum logic [3:0] {
      CMD_VERIFY     = 4'h1,
      CMD_CHECKSUM   = 4'h2,
      CMD_DESELECT   = 4'h3,
      CMD_IDLE       = 4'h4,
      CMD_ENC_ACT    = 4'h5,
      CMD_SEC_ERR    = 4'h6,
      CMD_WRITE_USER = 4'h7,
      CMD_READ_USER  = 4'h8,
      CMD_SET_ZONE   = 4'h9
   } cmd_code_t;

   // One command from the RF command decoder; arg is key index or zone number
   typedef struct packed {
      cmd_code_t          code;
      logic [7:0]         arg;
      logic [WORD_W-1:0]  host_rand;
      logic [WORD_W-1:0]  challenge_value;
      logic               cks_ok;
   } cmd_t;

   typedef struct packed {
      logic [KEY_W-1:0]   key_idx;
      logic [WORD_W-1:0]  cryptogram;
      logic [WORD_W-1:0]  host_rand;
   } eng_req_t;

   typedef struct packed {
      logic [WORD_W-1:0]  challenge_value;
      logic [WORD_W-1:0]  cryptogram;
      logic [WORD_W-1:0]  session_key;
   } eng_rsp_t;

   localparam logic [7:0] KEY_IDX_MAX = 8'h03;

   // Attempt counter coding
   localparam logic [7:0] FAIL_NONE = 8'hFF;
   localparam logic [7:0] FAIL_ONE  = 8'hEE;
   localparam logic [7:0] FAIL_TWO  = 8'hCC;
   localparam logic [7:0] FAIL_THR  = 8'h88;
   localparam logic [7:0] FAIL_LOCK = 8'h00;

   // Zone field layout and values
   localparam int         SM_MSB        = 2;
   localparam int         AUTH_KEY_LSB  = 6;
   localparam int         PGM_KEY_LSB   = 4;
   localparam logic [2:0] SEC_MODE_ENC  = 3'b110;
   localparam logic [2:0] SEC_MODE_OPEN = 3'b111;
   localparam logic [7:0] ZACC_RST      = 8'hFF;
   localparam logic [7:0] ZKEY_RST      = 8'hFF;

   // Register map: bank in addr[5:4], index in addr[3:0]
   localparam logic [1:0] BANK_ZACC   = 2'h0;
   localparam logic [1:0] BANK_ZKEY   = 2'h1;
   localparam logic [1:0] BANK_STATUS = 2'h2;
   localparam logic [1:0] BANK_FAIL   = 2'h3;
   localparam int         ST_KEY_LSB  = 2;
   localparam int         ST_ZONE_LSB = 4;
endpackage

// file: logic/comm_security_mode_control.sv
// Communication security mode control: mutual authentication, key sets and zone modes
// What this block does
// - key index zero to three picks key set
// - compare own challenge with host challenge
// - match stores cryptogram, session key, clears counter, ACK
// - counter and cryptogram rewritten when a started engine finishes with the field still present
// - zone change keeps authentication mode
// - checksum required on user writes when authenticated
// - passwords encrypted in authentication mode
// - leave mode on error, verify, power, deselect, idle
// - bad checksum resets engine, normal mode, NACK
// - three modes, normal by default
// - encryption only after authentication plus activation
// - zone mode field defaults ones, 110b and 111b
// - mode 110b needs encryption with zone key set
// - thermometer failure counter locks at zero
// - unsupported counter code means locked
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module comm_security_mode_control (
   input  wire logic                        sys_clk,
   input  wire logic                        arst_n,
   input  wire logic                        rf_field_ok,
   input  wire logic                        cmd_valid,
   input  wire csm_pkg::cmd_t               cmd,
   output logic                             cmd_ready,
   output logic                             rsp_valid,
   output logic                             rsp_ack,
   output logic                             eng_start,
   output csm_pkg::eng_req_t                eng_req,
   output logic                             eng_reset,
   input  wire logic                        eng_done,
   input  wire csm_pkg::eng_rsp_t           eng_rsp,
   output csm_pkg::comm_mode_t              comm_mode,
   output logic                             pw_encrypt,
   output logic                             data_encrypt,
   output logic                             cks_required,
   output logic                             rd_grant,
   output logic                             wr_grant,
   output logic [csm_pkg::WORD_W-1:0]       session_key,
   input  wire logic [5:0]                  reg_addr,
   input  wire logic [7:0]                  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic [7:0]                       reg_rdata
);
   typedef enum logic [0:0] {
      S_IDLE = 1'b0,
      S_WAIT = 1'b1
   } fsm_t;

   typedef struct packed {
      fsm_t                                          fsm;
      csm_pkg::comm_mode_t                           mode;
      logic [csm_pkg::KEY_W-1:0]                     key;
      logic [csm_pkg::ZONE_W-1:0]                    zone;
      logic [csm_pkg::NUM_KEYSETS-1:0][7:0]          fail_cnt;
      logic [csm_pkg::NUM_KEYSETS-1:0][csm_pkg::WORD_W-1:0] crypt;
      logic [csm_pkg::NUM_KEYSETS-1:0][csm_pkg::WORD_W-1:0] sess;
      logic [csm_pkg::NUM_ZONES-1:0][7:0]            zacc;
      logic [csm_pkg::NUM_ZONES-1:0][7:0]            zkey;
      logic [csm_pkg::WORD_W-1:0]                    rand_v;
      logic [csm_pkg::WORD_W-1:0]                    chal;
      logic                                          rsp_v;
      logic                                          rsp_a;
      logic                                          start;
      logic                                          e_rst;
      logic [7:0]                                    rdata;
   } state_t;

   localparam state_t ST_RST = '{
      fsm:   S_IDLE,
      mode:  csm_pkg::MODE_NORMAL,
      fail_cnt: {csm_pkg::NUM_KEYSETS{csm_pkg::FAIL_NONE}},
      zacc:  {csm_pkg::NUM_ZONES{csm_pkg::ZACC_RST}},
      zkey:  {csm_pkg::NUM_ZONES{csm_pkg::ZKEY_RST}},
      default: '0
   };

   state_t st_r;
   state_t st_nxt;

   // Unsupported codes count as locked, so a corrupted counter never reopens a key set
   function automatic logic fail_locked(input logic [7:0] v);
      case (v)
         csm_pkg::FAIL_NONE, csm_pkg::FAIL_ONE, csm_pkg::FAIL_TWO, csm_pkg::FAIL_THR: fail_locked = 1'b0;
         default: fail_locked = 1'b1;
      endcase
   endfunction

   function automatic logic [7:0] fail_next(input logic [7:0] v);
      case (v)
         csm_pkg::FAIL_NONE: fail_next = csm_pkg::FAIL_ONE;
         csm_pkg::FAIL_ONE:  fail_next = csm_pkg::FAIL_TWO;
         csm_pkg::FAIL_TWO:  fail_next = csm_pkg::FAIL_THR;
         default:            fail_next = csm_pkg::FAIL_LOCK;
      endcase
   endfunction

   logic [2:0]                sec_mode;
   logic [csm_pkg::KEY_W-1:0] zone_key;
   logic                      key_match;
   logic [1:0]                bank;
   logic [3:0]                idx;

   always_comb begin
      sec_mode = st_r.zacc[st_r.zone][csm_pkg::SM_MSB:0];
      zone_key = st_r.zkey[st_r.zone][csm_pkg::AUTH_KEY_LSB +: csm_pkg::KEY_W];
      key_match = (st_r.mode == csm_pkg::MODE_ENC) && (st_r.key == zone_key);
      bank = reg_addr[5:4];
      idx = reg_addr[3:0];
   end

   // Any zone mode other than open is gated on encryption with the zone's key set
   assign rd_grant     = (sec_mode == csm_pkg::SEC_MODE_OPEN) || key_match;
   assign wr_grant     = (sec_mode == csm_pkg::SEC_MODE_OPEN) || key_match;
   assign cks_required = (st_r.mode != csm_pkg::MODE_NORMAL)
                         || (sec_mode == csm_pkg::SEC_MODE_ENC);
   assign pw_encrypt   = (st_r.mode != csm_pkg::MODE_NORMAL);
   assign data_encrypt = (st_r.mode == csm_pkg::MODE_ENC);
   assign comm_mode    = st_r.mode;
   assign session_key  = st_r.sess[st_r.key];
   assign cmd_ready    = (st_r.fsm == S_IDLE);
   assign rsp_valid    = st_r.rsp_v;
   assign rsp_ack      = st_r.rsp_a;
   assign eng_start    = st_r.start;
   assign eng_reset    = st_r.e_rst;
   assign reg_rdata    = st_r.rdata;
   assign eng_req      = '{key_idx: st_r.key, cryptogram: st_r.crypt[st_r.key], host_rand: st_r.rand_v};

   always_comb begin
      st_nxt = st_r;
      st_nxt.rsp_v = 1'b0;
      st_nxt.rsp_a = 1'b0;
      st_nxt.start = 1'b0;
      st_nxt.e_rst = 1'b0;
      st_nxt.rdata = '0;

      if (reg_rd) begin
         case (bank)
            csm_pkg::BANK_ZACC: st_nxt.rdata = st_r.zacc[idx];
            csm_pkg::BANK_ZKEY: st_nxt.rdata = st_r.zkey[idx];
            csm_pkg::BANK_STATUS: begin
               st_nxt.rdata = {st_r.zone, st_r.key, st_r.mode};
            end
            csm_pkg::BANK_FAIL: begin
               if (idx < 4'(csm_pkg::NUM_KEYSETS)) begin
                  st_nxt.rdata = st_r.fail_cnt[idx[csm_pkg::KEY_W-1:0]];
               end
            end
            default: st_nxt.rdata = '0;
         endcase
      end
      if (reg_wr) begin
         case (bank)
            csm_pkg::BANK_ZACC: st_nxt.zacc[idx] = reg_wdata;
            csm_pkg::BANK_ZKEY: st_nxt.zkey[idx] = reg_wdata;
            default: ;
         endcase
      end

      case (st_r.fsm)
         S_IDLE: begin
            if (cmd_valid) begin
               st_nxt.rsp_v = 1'b1;
               case (cmd.code)
                  csm_pkg::CMD_VERIFY: begin
                     st_nxt.mode = csm_pkg::MODE_NORMAL;
                     if (cmd.arg <= csm_pkg::KEY_IDX_MAX) begin
                        st_nxt.key = cmd.arg[csm_pkg::KEY_W-1:0];
                        if (!fail_locked(st_r.fail_cnt[cmd.arg[csm_pkg::KEY_W-1:0]])) begin
                           st_nxt.rand_v = cmd.host_rand;
                           st_nxt.chal = cmd.challenge_value;
                           st_nxt.start = 1'b1;
                           st_nxt.rsp_v = 1'b0;
                           st_nxt.fsm = S_WAIT;
                        end
                     end
                  end
                  csm_pkg::CMD_CHECKSUM: begin
                     if (cmd.cks_ok) begin
                        st_nxt.rsp_a = 1'b1;
                     end else begin
                        st_nxt.mode = csm_pkg::MODE_NORMAL;
                        st_nxt.e_rst = 1'b1;
                     end
                  end
                  csm_pkg::CMD_DESELECT, csm_pkg::CMD_IDLE, csm_pkg::CMD_SEC_ERR: begin
                     st_nxt.mode = csm_pkg::MODE_NORMAL;
                     st_nxt.e_rst = 1'b1;
                     st_nxt.rsp_a = (cmd.code != csm_pkg::CMD_SEC_ERR);
                  end
                  csm_pkg::CMD_ENC_ACT: begin
                     if (st_r.mode == csm_pkg::MODE_AUTH) begin
                        st_nxt.mode = csm_pkg::MODE_ENC;
                        st_nxt.rsp_a = 1'b1;
                     end
                  end
                  csm_pkg::CMD_SET_ZONE: begin
                     st_nxt.zone = cmd.arg[csm_pkg::ZONE_W-1:0];
                     st_nxt.rsp_a = 1'b1;
                  end
                  csm_pkg::CMD_WRITE_USER: begin
                     if (cks_required && !cmd.cks_ok) begin
                        st_nxt.mode = csm_pkg::MODE_NORMAL;
                        st_nxt.e_rst = 1'b1;
                     end else begin
                        st_nxt.rsp_a = wr_grant;
                     end
                  end
                  csm_pkg::CMD_READ_USER: st_nxt.rsp_a = rd_grant;
                  default: ;
               endcase
            end
         end
         S_WAIT: begin
            if (!rf_field_ok) begin
               st_nxt.fsm = S_IDLE;
            end else if (eng_done) begin
               st_nxt.fsm = S_IDLE;
               st_nxt.rsp_v = 1'b1;
               st_nxt.crypt[st_r.key] = eng_rsp.cryptogram;
               if (eng_rsp.challenge_value == st_r.chal) begin
                  st_nxt.sess[st_r.key] = eng_rsp.session_key;
                  st_nxt.fail_cnt[st_r.key] = csm_pkg::FAIL_NONE;
                  st_nxt.mode = csm_pkg::MODE_AUTH;
                  st_nxt.rsp_a = 1'b1;
               end else begin
                  st_nxt.fail_cnt[st_r.key] = fail_next(st_r.fail_cnt[st_r.key]);
               end
            end
         end
         default: st_nxt.fsm = S_IDLE;
      endcase

      // Power loss wins over mode, responses and engine start; the mode must not survive the field dropping
      if (!rf_field_ok) begin
         st_nxt.mode = csm_pkg::MODE_NORMAL;
         st_nxt.rsp_v = 1'b0;
         st_nxt.rsp_a = 1'b0;
         st_nxt.start = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

// file: verification/csm_checker_assertions.sv
// Port assertions for the communication security mode control
`timescale 1ns/100ps
`default_nettype none
module csm_checker (
   input wire logic                          sys_clk,
   input wire logic                          arst_n,
   input wire logic                          rf_field_ok,
   input wire logic                          cmd_valid,
   input wire csm_pkg::cmd_t                 cmd,
   input wire logic                          cmd_ready,
   input wire logic                          rsp_valid,
   input wire logic                          rsp_ack,
   input wire logic                          eng_start,
   input wire csm_pkg::eng_req_t             eng_req,
   input wire logic                          eng_reset,
   input wire logic                          eng_done,
   input wire csm_pkg::eng_rsp_t             eng_rsp,
   input wire csm_pkg::comm_mode_t           comm_mode,
   input wire logic                          pw_encrypt,
   input wire logic                          data_encrypt,
   input wire logic                          cks_required,
   input wire logic [csm_pkg::WORD_W-1:0]    session_key
);
   logic [63:0] chal_q;
   wire         take = cmd_valid && cmd_ready && rf_field_ok;
   wire         vfy  = take && cmd.code == csm_pkg::CMD_VERIFY;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // Host challenge is gone from the command port once taken, so keep it
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n) chal_q <= '0;
      else if (vfy) chal_q <= cmd.challenge_value;
   chk_key_select: assert property (vfy && cmd.arg <= csm_pkg::KEY_IDX_MAX |=>
      (eng_start && eng_req.key_idx == $past(cmd.arg[1:0])) || (rsp_valid && !rsp_ack)) else $error("key select");
   chk_bad_index: assert property (vfy && cmd.arg > csm_pkg::KEY_IDX_MAX |=>
      rsp_valid && !rsp_ack && !eng_start) else $error("bad index");
   chk_match_ack: assert property (eng_done && rf_field_ok |=>
      rsp_valid && rsp_ack == ($past(eng_rsp.challenge_value) == chal_q)) else $error("match ack");
   chk_auth_entry: assert property (rsp_valid && rsp_ack && $past(eng_done) |->
      comm_mode == csm_pkg::MODE_AUTH && session_key == $past(eng_rsp.session_key)) else $error("auth entry");
   chk_verify_exit: assert property (vfy |=> comm_mode == csm_pkg::MODE_NORMAL) else $error("verify exit");
   chk_exit_cmds: assert property (take && cmd.code inside {csm_pkg::CMD_DESELECT, csm_pkg::CMD_IDLE,
      csm_pkg::CMD_SEC_ERR} |=> eng_reset && comm_mode == csm_pkg::MODE_NORMAL) else $error("exit cmd");
   chk_field_loss: assert property (!rf_field_ok |=>
      comm_mode == csm_pkg::MODE_NORMAL && !rsp_valid) else $error("field loss");
   chk_bad_cks: assert property (take && cmd.code == csm_pkg::CMD_CHECKSUM && !cmd.cks_ok |=>
      rsp_valid && !rsp_ack && eng_reset && comm_mode == csm_pkg::MODE_NORMAL) else $error("bad checksum");
   chk_zone_keep: assert property (take && cmd.code == csm_pkg::CMD_SET_ZONE |=>
      rsp_ack && comm_mode == $past(comm_mode)) else $error("zone keep");
   chk_mode_decode: assert property (pw_encrypt == (comm_mode != csm_pkg::MODE_NORMAL) &&
      data_encrypt == (comm_mode == csm_pkg::MODE_ENC)) else $error("mode decode");
   chk_enc_entry: assert property (comm_mode == csm_pkg::MODE_ENC && $past(comm_mode) != csm_pkg::MODE_ENC |->
      $past(comm_mode) == csm_pkg::MODE_AUTH && $past(take && cmd.code == csm_pkg::CMD_ENC_ACT)) else $error("enc");
   chk_auth_cks: assert property (comm_mode == csm_pkg::MODE_AUTH |-> cks_required) else $error("auth cks");
   chk_busy_wait: assert property (eng_start |-> !cmd_ready) else $error("busy wait");
   cov_auth: cover property (rsp_valid && rsp_ack && $past(eng_done));
   cov_lock: cover property (vfy ##1 rsp_valid && !rsp_ack);
   cov_enc: cover property (comm_mode == csm_pkg::MODE_ENC);
endmodule
bind comm_security_mode_control csm_checker csm_checker_inst (.sys_clk, .arst_n, .rf_field_ok, .cmd_valid, .cmd,
   .cmd_ready, .rsp_valid, .rsp_ack, .eng_start, .eng_req, .eng_reset, .eng_done, .eng_rsp, .comm_mode,
   .pw_encrypt, .data_encrypt, .cks_required, .session_key);
`default_nettype wire

// file: verification/crypto_engine_model.sv
// Behavioural crypto engine on the far side of the control block
`timescale 1ns/100ps
`default_nettype none
module crypto_engine_model (
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   input  wire logic              eng_start,
   input  wire csm_pkg::eng_req_t eng_req,
   input  wire logic              eng_reset,
   input  wire logic [3:0]        lat,
   output logic                   eng_done,
   output csm_pkg::eng_rsp_t      eng_rsp
);
   logic [63:0] chal;
   int          cnt;
   // Toy cipher: cheap, yet every request bit moves the result
   assign chal    = eng_req.host_rand ^ eng_req.cryptogram ^ {62'h0, eng_req.key_idx};
   // Outside the done cycle the challenge and cryptogram lines never show the answer; the session key lines show ~chal either way
   assign eng_rsp = eng_done ? {chal, chal[31:0], chal[63:32], ~chal} : {3{~chal}};
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt      <= 0;
         eng_done <= 1'b0;
      end else begin
         eng_done <= (cnt == 1);
         cnt      <= eng_start ? lat + 1 : (cnt > 0 && !eng_reset) ? cnt - 1 : 0;
      end
   end
endmodule
`default_nettype wire

// file: verification/comm_security_mode_control_test.sv
// Self-checking bench for the communication security mode control
`timescale 1ns/100ps
`default_nettype none
module comm_security_mode_control_test;
   localparam logic [63:0] RND = 64'h0123_4567_89AB_CDEF;
   logic                sys_clk = 1'b0, arst_n = 1'b0, rf_field_ok = 1'b1, cmd_valid = 1'b0;
   logic                reg_wr = 1'b0, reg_rd = 1'b0, cmd_ready, rsp_valid, rsp_ack, eng_start, eng_reset;
   logic                eng_done, pw_encrypt, data_encrypt, cks_required, rd_grant, wr_grant, ack;
   logic [5:0]          reg_addr = 6'h00;
   logic [7:0]          reg_wdata = 8'h00, reg_rdata, d, fac [4];
   logic [3:0]          lat = 4'h0;
   logic [63:0]         session_key, crypt [4];
   csm_pkg::cmd_t       cmd = '0;
   csm_pkg::eng_req_t   eng_req;
   csm_pkg::eng_rsp_t   eng_rsp;
   csm_pkg::comm_mode_t comm_mode;
   int                  error_cnt = 0, num_checks = 0, cyc = 0;
   always #4 sys_clk = ~sys_clk;
   comm_security_mode_control comm_security_mode_control_inst (.sys_clk, .arst_n, .rf_field_ok, .cmd_valid, .cmd,
      .cmd_ready, .rsp_valid, .rsp_ack, .eng_start, .eng_req, .eng_reset, .eng_done, .eng_rsp, .comm_mode,
      .pw_encrypt, .data_encrypt, .cks_required, .rd_grant, .wr_grant, .session_key, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata);
   crypto_engine_model crypto_engine_model_inst (.sys_clk, .arst_n, .eng_start, .eng_req, .eng_reset, .lat,
      .eng_done, .eng_rsp);
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rg(input logic w, input logic [5:0] a, input logic [7:0] wd);
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= wd;
      @(posedge sys_clk);
      {reg_wr, reg_rd} <= 2'b00;
      #1 d = reg_rdata;
   endtask
   task automatic send(input csm_pkg::cmd_code_t c, input logic [7:0] a, input logic [63:0] chal, input logic ok);
      int n;
      n = 0;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd <= '{c, a, RND, chal, ok};
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      #1;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         #1 n++;
      end
      if (rsp_valid !== 1'b1) chk("response", 1'b1, 1'b0);
      ack = rsp_ack;
   endtask
   task automatic verify(input logic [1:0] k, input logic good, input logic exp_ack);
      logic [63:0] chal;
      chal = RND ^ crypt[k] ^ {62'h0, k};
      rg(1'b0, {2'h3, 2'h0, k}, 8'h00);
      chk("counter before", fac[k], d); // Host reads the counter first
      send(csm_pkg::CMD_VERIFY, {6'h0, k}, good ? chal : ~chal, 1'b1);
      chk("verify ack", exp_ack, ack);
      if (fac[k] != 8'h00) crypt[k] = {chal[31:0], chal[63:32]};
      fac[k] = exp_ack ? 8'hFF : {fac[k][6:4], 1'b0, fac[k][2:0], 1'b0};
      chk("verify mode", exp_ack ? csm_pkg::MODE_AUTH : csm_pkg::MODE_NORMAL, comm_mode);
      if (exp_ack) chk("session key", ~chal, session_key);
      rg(1'b0, {2'h3, 2'h0, k}, 8'h00);
      chk("counter after", fac[k], d);
   endtask
   task automatic t_reset();
      for (int k = 0; k < 4; k++) begin
         rg(1'b0, {2'h3, 2'h0, 2'(k)}, 8'h00);
         chk("counter reset", 8'hFF, d);
      end
      rg(1'b0, 6'h00, 8'h00);
      chk("zone mode reset", 8'hFF, d);
      rg(1'b1, 6'h20, 8'h55);
      rg(1'b0, 6'h20, 8'h00);
      chk("status", 8'h00, d);
      rg(1'b0, 6'h34, 8'h00);
      chk("unmapped", 8'h00, d);
   endtask
   task automatic t_auth();
      for (int k = 0; k < 4; k++) begin
         lat = 4'(3 * k);
         verify(2'(k), 1'b1, 1'b1);
         chk("pw crypt", 1'b1, pw_encrypt);
      end
      send(csm_pkg::CMD_SET_ZONE, 8'h05, '0, 1'b1);
      chk("zone mode", csm_pkg::MODE_AUTH, comm_mode);
      chk("open grant", 1'b1, rd_grant);
      chk("open cks", 1'b1, cks_required);
      send(csm_pkg::CMD_WRITE_USER, 8'h00, '0, 1'b0);
      chk("bad write", 1'b0, ack);
   endtask
   task automatic t_exits();
      csm_pkg::cmd_code_t c [4] = '{csm_pkg::CMD_DESELECT, csm_pkg::CMD_IDLE, csm_pkg::CMD_SEC_ERR,
                                    csm_pkg::CMD_CHECKSUM};
      for (int i = 0; i < 4; i++) begin
         verify(2'h1, 1'b1, 1'b1);
         send(c[i], 8'h00, '0, 1'b0); // Checksum exit is the recommended one
         chk("exit mode", csm_pkg::MODE_NORMAL, comm_mode);
      end
      chk("cks nack", 1'b0, ack);
      verify(2'h1, 1'b1, 1'b1);
      @(posedge sys_clk) rf_field_ok <= 1'b0;
      @(posedge sys_clk) rf_field_ok <= 1'b1;
      #1 chk("field loss", csm_pkg::MODE_NORMAL, comm_mode);
      verify(2'h1, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) verify(2'h2, 1'b0, 1'b0); // Retry after each refusal
      verify(2'h2, 1'b1, 1'b0);
      send(csm_pkg::CMD_VERIFY, 8'h04, RND, 1'b1);
      chk("index range", 1'b0, ack);
   endtask
   task automatic t_enc();
      send(csm_pkg::CMD_ENC_ACT, 8'h00, '0, 1'b1);
      chk("enc from normal", 1'b0, ack);
      rg(1'b1, 6'h06, 8'hFE);
      rg(1'b1, 6'h16, 8'h3F);
      send(csm_pkg::CMD_SET_ZONE, 8'h06, '0, 1'b1);
      verify(2'h0, 1'b1, 1'b1);
      chk("auth no grant", 1'b0, rd_grant | wr_grant);
      send(csm_pkg::CMD_ENC_ACT, 8'h00, '0, 1'b1);
      chk("enc mode", csm_pkg::MODE_ENC, comm_mode);
      chk("data crypt", 1'b1, data_encrypt);
      chk("enc grant", 1'b1, rd_grant & wr_grant & cks_required);
      send(csm_pkg::CMD_READ_USER, 8'h00, '0, 1'b1);
      chk("enc read", 1'b1, ack);
      rg(1'b1, 6'h16, 8'h7F);
      chk("other key", 1'b0, rd_grant);
      send(csm_pkg::CMD_DESELECT, 8'h00, '0, 1'b1);
      chk("enc exit", csm_pkg::MODE_NORMAL, comm_mode);
   endtask
   task automatic test_done();
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      for (int k = 0; k < 4; k++) begin
         crypt[k] = '0;
         fac[k] = 8'hFF;
      end
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_reset();
      t_auth();
      t_exits();
      t_enc();
      test_done();
   end
   // Whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
endmodule
`default_nettype wire
